//--- hdl/lpc_pkg.sv
// Function
// RQ1 - Each load takes six-bit code from accumulator
// RQ2 - Two buffer sections, 120 codes each
// RQ3 - Print uses the section loaded last
// RQ4 - Loading other section overlaps with printing
// RQ5 - Printed section emptied after its last character
// RQ6 - Load and print sections alternate internally
// RQ7 - Print command loads three-bit format register
// RQ8 - Paper advances until selected channel hole
// RQ9 - Load takes 1.6 ms, then ready sets
// RQ10 - Ready flag requests program interrupt
// RQ11 - Code 6652 clears the ready flag
// RQ12 - Code 6655 formats, prints, maybe advances
// RQ13 - Advance bit zero prints without advance
// RQ14 - Code 6661 skips when ready set
// RQ15 - Code 6662 clears both buffer sections
// RQ16 - Code 6664 loads next buffer position
// RQ17 - At most 300 lines per minute
// RQ18 - Decode device and pulse bits, ascending
// RQ19 - Per-section counters, loads past 120 ignored
package lpc_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int LOAD_TIME_US    = 1600;
    localparam int LOAD_CYCLES     = LOAD_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int LINES_PER_MIN   = 300;
    localparam int LINE_MIN_MS     = 60000 / LINES_PER_MIN;
    localparam int LINE_MIN_CYCLES = (LINE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // Buffer geometry
    localparam int LINE_CHARS = 120;
    localparam int POS_W      = 7;
    localparam int CHAR_W     = 6;
    localparam int FMT_W      = 3;
    localparam int CHANNELS   = 8;
    localparam logic [CHAR_W-1:0] BLANK_CODE = 6'h00;
    // Register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_STATE  = 8'h0C;
    // Command word layout
    localparam int AC_LSB  = 0;
    localparam int AC_W    = 12;
    localparam int IR_LSB  = 12;
    localparam int IR_W    = 12;
    localparam int SKIP_BIT = 0;
    // Accumulator fields (machine bit 11 is our bit 0)
    localparam int CHAR_LSB = 0;
    localparam int FMT_LSB  = 0;
    localparam int ADV_BIT  = 3;
    // Instruction fields: opcode, device select, pulse bits
    localparam int OP_LSB  = 9;
    localparam int DEV_LSB = 3;
    localparam logic [2:0] IOT_OP  = 3'h6;
    localparam logic [5:0] DEV_CTL = 6'h35; // Octal 65
    localparam logic [5:0] DEV_BUF = 6'h36; // Octal 66
    localparam int P1 = 0;
    localparam int P2 = 1;
    localparam int P4 = 2;
    // Status and mask bits
    localparam int ST_READY = 0;
    localparam int ST_LINE  = 1;
    localparam int ST_ADV   = 2;
    localparam int ST_W     = 3;
    // State register fields
    localparam int SR_READY = 0;
    localparam int SR_LSEL  = 1;
    localparam int SR_PSEL  = 2;
    localparam int SR_BUSY  = 3;
    localparam int SR_ADV   = 4;
    localparam int SR_FMT   = 8;
    localparam int SR_CNT   = 16;
    // Reset values
    localparam logic READY_RST = 1'b1;
    // Print engine states
    typedef enum logic [4:0] {
        LPC_IDLE = 5'h01,
        LPC_STRB = 5'h02,
        LPC_WACK = 5'h04,
        LPC_ADV  = 5'h08,
        LPC_PACE = 5'h10
    } lpc_state_e;
endpackage : lpc_pkg

//--- hdl/lpc_line_printer_control.sv
`timescale 1ns/1ps
module lpc_line_printer_control
    import lpc_pkg::*;
#(
    parameter int unsigned LOAD_CYC = LOAD_CYCLES,
    parameter int unsigned LINE_CYC = LINE_MIN_CYCLES
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    output logic                     skipReq,
    output logic      [CHAR_W-1:0]   prnCode,
    output logic                     prnStrobe,
    output logic                     prnLineDone,
    input  wire logic                prnAck,
    output logic                     paperAdvance,
    input  wire logic [CHANNELS-1:0] tapeHole
);

    // Instruction hit: opcode, device select and one pulse bit
    function automatic logic iotHit(input logic [IR_W-1:0] ir,
                                    input logic [5:0] dev, input int pb);
        return (ir[OP_LSB +: 3] == IOT_OP) && (ir[DEV_LSB +: 6] == dev)
               && ir[pb];
    endfunction : iotHit

    // Line storage, one row per section
    logic [CHAR_W-1:0] lineMem [0:1][0:LINE_CHARS-1]; // RQ2
    logic [POS_W-1:0]  secCount [0:1];      // Codes held per section
    logic              loadSel;             // Section being loaded
    logic              printSel;            // Section being printed
    logic              readyFlag;           // Ready for next code
    logic              ldBusy;              // Code transfer running
    logic [31:0]       ldTmr;               // Transfer timer
    logic              ldDone;              // Transfer finished
    logic [FMT_W-1:0]  fmtReg;              // Format channel
    logic              advEn;               // Advance after line
    logic              advLeft;             // Left starting hole
    lpc_state_e        state;               // Print engine state
    logic [POS_W-1:0]  prnPos;              // Print position
    logic [31:0]       paceTmr;             // Line pacing timer
    logic [ST_W-1:0]   status;              // Sticky events
    logic [ST_W-1:0]   mask;                // Interrupt mask
    logic              skipLast;            // Last skip answer
    logic              ackMeta;             // Ack sync stage 1
    logic              ackSync;             // Ack sync stage 2
    logic              ackPrev;             // Ack edge history
    logic [CHANNELS-1:0] holeMeta;          // Hole sync stage 1
    logic [CHANNELS-1:0] holeSync;          // Hole sync stage 2

    // Decoded bus and instruction strobes
    logic             wr;
    logic             cmdWr;
    logic [IR_W-1:0]  ir;
    logic [AC_W-1:0]  ac;
    logic             fmtClr;
    logic             clrFlag;
    logic             prCmd;
    logic             skipCmd;
    logic             clrAll;
    logic             ldCmd;
    logic             ldAcc;
    logic             storeOk;
    logic [POS_W-1:0] storePos;
    logic             prAcc;
    logic             lineEnd;
    logic             advDone;
    logic             ackRise;
    logic             mapped;

    // Bus handshake and decode
    always_comb begin
        pready  = ce;
        wr      = ce && psel && penable && pwrite;
        cmdWr   = wr && (paddr == REG_CMD);
        ir      = pwdata[IR_LSB +: IR_W];
        ac      = pwdata[AC_LSB +: AC_W];
        mapped  = (paddr == REG_CMD) || (paddr == REG_STATUS)
                  || (paddr == REG_MASK) || (paddr == REG_STATE);
        pslverr = psel && penable && !mapped;
    end

    // Pulse bits act in ascending order within one instruction
    always_comb begin
        fmtClr   = cmdWr && iotHit(ir, DEV_CTL, P1); // RQ18
        clrFlag  = cmdWr && iotHit(ir, DEV_CTL, P2); // RQ11
        prCmd    = cmdWr && iotHit(ir, DEV_CTL, P4); // RQ12
        skipCmd  = cmdWr && iotHit(ir, DEV_BUF, P1); // RQ14
        clrAll   = cmdWr && iotHit(ir, DEV_BUF, P2); // RQ15
        ldCmd    = cmdWr && iotHit(ir, DEV_BUF, P4); // RQ16
        ldAcc    = ldCmd && !ldBusy;
        // Clear pulse precedes load pulse, so load lands at 0
        storePos = clrAll ? '0 : secCount[loadSel]; // RQ18
        storeOk  = ldAcc && (storePos < POS_W'(LINE_CHARS)); // RQ19
        prAcc    = prCmd && (state == LPC_IDLE);
        ackRise  = ackSync && !ackPrev;
        lineEnd  = ce && (state == LPC_WACK) && ackRise
                   && (prnPos == POS_W'(LINE_CHARS - 1));
        advDone  = ce && (state == LPC_ADV) && advLeft && holeSync[fmtReg];
        ldDone   = ce && ldBusy && (ldTmr == '0);
    end

    // Pin synchronisers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ackMeta  <= 1'b0;
            ackSync  <= 1'b0;
            ackPrev  <= 1'b0;
            holeMeta <= '0;
            holeSync <= '0;
        end else if (ce) begin
            ackMeta  <= prnAck;
            ackSync  <= ackMeta;
            ackPrev  <= ackSync;
            holeMeta <= tapeHole;
            holeSync <= holeMeta;
        end
    end

    // Character store into the loading section
    always_ff @(posedge sys_clk) begin
        if (storeOk) begin
            lineMem[loadSel][storePos] <= ac[CHAR_LSB +: CHAR_W]; // RQ1 RQ4
        end
    end

    // Per-section position counters
    generate
        for (genvar s = 0; s < 2; s++) begin : gSec
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    secCount[s] <= '0;
                end else if (ce) begin
                    if (storeOk && (loadSel == 1'(s))) begin
                        secCount[s] <= storePos + 1'b1; // RQ19
                    end else if (clrAll) begin
                        secCount[s] <= '0; // RQ15
                    end else if (lineEnd && (printSel == 1'(s))) begin
                        secCount[s] <= '0; // RQ5
                    end
                end
            end
        end
    endgenerate

    // Code transfer timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ldBusy <= 1'b0;
            ldTmr  <= '0;
        end else if (ce) begin
            if (ldAcc) begin
                ldBusy <= 1'b1;
                ldTmr  <= 32'(LOAD_CYC - 1); // RQ9
            end else if (ldDone) begin
                ldBusy <= 1'b0;
            end else if (ldBusy) begin
                ldTmr <= ldTmr - 1'b1;
            end
        end
    end

    // Ready flag: completion sets, clear loses to set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readyFlag <= READY_RST;
        end else if (ce) begin
            if (ldDone) begin
                readyFlag <= 1'b1; // RQ9
            end else if (clrFlag || ldAcc) begin
                readyFlag <= 1'b0; // RQ11
            end
        end
    end

    // Section alternation
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loadSel  <= 1'b0;
            printSel <= 1'b0;
        end else if (ce && prAcc) begin
            printSel <= loadSel; // RQ3
            loadSel  <= !loadSel; // RQ6
        end
    end

    // Format register and advance enable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fmtReg <= '0;
            advEn  <= 1'b0;
        end else if (ce) begin
            if (prCmd) begin
                fmtReg <= ac[FMT_LSB +: FMT_W]; // RQ7 RQ12
            end else if (fmtClr) begin
                fmtReg <= '0;
            end
            if (prAcc) begin
                advEn <= ac[ADV_BIT]; // RQ13
            end
        end
    end

    // Print engine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state        <= LPC_IDLE;
            prnPos       <= '0;
            prnCode      <= BLANK_CODE;
            prnStrobe    <= 1'b0;
            prnLineDone  <= 1'b0;
            paperAdvance <= 1'b0;
            advLeft      <= 1'b0;
        end else if (ce) begin
            prnStrobe   <= 1'b0;
            prnLineDone <= 1'b0;
            case (state)
                LPC_IDLE: begin
                    if (prAcc) begin
                        prnPos <= '0;
                        state  <= LPC_STRB;
                    end
                end
                LPC_STRB: begin
                    // Unloaded positions print blank
                    prnCode   <= (prnPos < secCount[printSel])
                                 ? lineMem[printSel][prnPos] : BLANK_CODE;
                    prnStrobe <= 1'b1;
                    state     <= LPC_WACK;
                end
                LPC_WACK: begin
                    if (lineEnd) begin
                        prnLineDone <= 1'b1;
                        advLeft     <= 1'b0;
                        if (advEn) begin
                            paperAdvance <= 1'b1; // RQ8
                            state        <= LPC_ADV;
                        end else begin
                            state <= LPC_PACE; // RQ13
                        end
                    end else if (ackRise) begin
                        prnPos <= prnPos + 1'b1;
                        state  <= LPC_STRB;
                    end
                end
                LPC_ADV: begin
                    // Move off a hole already under the sensor first
                    if (!holeSync[fmtReg]) begin
                        advLeft <= 1'b1;
                    end
                    if (advDone) begin
                        paperAdvance <= 1'b0; // RQ8
                        state        <= LPC_PACE;
                    end
                end
                LPC_PACE: begin
                    if (paceTmr == '0) begin
                        state <= LPC_IDLE; // RQ17
                    end
                end
                default: begin
                    state        <= LPC_IDLE;
                    paperAdvance <= 1'b0;
                end
            endcase
        end
    end

    // Line period timer keeps the rate within limit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            paceTmr <= '0;
        end else if (ce) begin
            if (prAcc) begin
                paceTmr <= 32'(LINE_CYC - 1); // RQ17
            end else if (paceTmr != '0) begin
                paceTmr <= paceTmr - 1'b1;
            end
        end
    end

    // Skip answer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            skipReq  <= 1'b0;
            skipLast <= 1'b0;
        end else if (ce) begin
            skipReq <= skipCmd && readyFlag; // RQ14
            if (skipCmd) begin
                skipLast <= readyFlag;
            end
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status <= '0;
            mask   <= '0;
        end else if (ce) begin
            for (int i = 0; i < ST_W; i++) begin
                if ((i == ST_READY && ldDone) || (i == ST_LINE && lineEnd)
                    || (i == ST_ADV && advDone)) begin
                    status[i] <= 1'b1; // RQ10
                end else if (wr && paddr == REG_STATUS && pwdata[i]) begin
                    status[i] <= 1'b0;
                end else if (i == ST_READY && clrFlag) begin
                    status[i] <= 1'b0; // RQ11
                end
            end
            if (wr && paddr == REG_MASK) begin
                mask <= pwdata[ST_W-1:0];
            end
        end
    end

    // Interrupt output
    always_comb begin
        irq = |(status & mask); // RQ10
    end

    // Read data captured in the setup cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
        end else if (ce && psel && !penable) begin
            prdata <= '0;
            case (paddr)
                REG_CMD:    prdata[SKIP_BIT] <= skipLast;
                REG_STATUS: prdata[ST_W-1:0] <= status;
                REG_MASK:   prdata[ST_W-1:0] <= mask;
                REG_STATE: begin
                    prdata[SR_READY]             <= readyFlag;
                    prdata[SR_LSEL]              <= loadSel;
                    prdata[SR_PSEL]              <= printSel;
                    prdata[SR_BUSY]              <= (state != LPC_IDLE);
                    prdata[SR_ADV]               <= paperAdvance;
                    prdata[SR_FMT +: FMT_W]      <= fmtReg;
                    prdata[SR_CNT +: POS_W]      <= secCount[loadSel];
                end
                default:    prdata <= '0;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ready_set_a: assert property (ldDone |=> readyFlag) // RQ9
        else $error("ready not set after transfer");
    ready_time_a: assert property (ce && ldAcc |=> !readyFlag) // RQ9
        else $error("ready stayed high at load start");
    ready_irq_a: assert property (status[ST_READY] && mask[ST_READY] |-> irq) // RQ10
        else $error("interrupt missing for ready");
    flag_clear_a: assert property (clrFlag && !ldDone |=> !readyFlag) // RQ11
        else $error("ready flag not cleared");
    char_store_a: assert property (storeOk && !clrAll
        |=> secCount[$past(loadSel)] == $past(storePos) + 1'b1) // RQ16
        else $error("load did not advance position");
    count_cap_a: assert property (secCount[0] <= POS_W'(LINE_CHARS)
        && secCount[1] <= POS_W'(LINE_CHARS)) // RQ19
        else $error("section count beyond line");
    sect_toggle_a: assert property (prAcc
        |=> printSel == $past(loadSel) && loadSel != $past(loadSel)) // RQ6
        else $error("sections did not alternate");
    fmt_load_a: assert property (prCmd |=> fmtReg == $past(ac[FMT_LSB +: FMT_W])) // RQ7
        else $error("format not loaded");
    sect_clear_a: assert property (lineEnd && !clrAll && !storeOk
        |=> secCount[printSel] == '0) // RQ5
        else $error("printed section not emptied");
    both_clear_a: assert property (clrAll && !storeOk
        |=> secCount[0] == '0 && secCount[1] == '0) // RQ15
        else $error("clear both failed");
    no_adv_a: assert property (paperAdvance |-> advEn) // RQ13
        else $error("advance without enable");
    adv_stop_a: assert property (advDone |=> !paperAdvance) // RQ8
        else $error("advance did not stop at hole");
    skip_a: assert property (skipCmd && readyFlag |=> skipReq) // RQ14
        else $error("skip not requested");
    pace_a: assert property (state == LPC_PACE && paceTmr > 32'd1
        |=> state == LPC_PACE) // RQ17
        else $error("line period shortened");

    load_print_c: cover property (ldAcc && state != LPC_IDLE);
    line_adv_c:   cover property (advDone);
    skip_c:       cover property (skipReq);
    full_line_c:  cover property (lineEnd && secCount[printSel] == POS_W'(LINE_CHARS));

endmodule : lpc_line_printer_control

//--- sim/lpc_printer_model.sv
`timescale 1ns/1ps
module lpc_printer_model
    import lpc_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                slow,
    input  wire logic [CHAR_W-1:0]   prnCode,
    input  wire logic                prnStrobe,
    input  wire logic                prnLineDone,
    output logic                     prnAck,
    input  wire logic                paperAdvance,
    output logic      [CHANNELS-1:0] tapeHole
);
    logic [CHAR_W-1:0] codes [0:LINE_CHARS-1]; // Codes of the last line
    logic [7:0]        pos;                      // Codes taken this line
    logic [7:0]        lineLen;                  // Length of last line
    logic [4:0]        ackCnt;                   // Ack timer
    logic [5:0]        step;                     // Tape position
    // Ack after a short or long delay, held four cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ackCnt <= 5'h00;
        end else if (prnStrobe) begin
            ackCnt <= slow ? 5'h10 : 5'h07;
        end else if (ackCnt != 5'h00) begin
            ackCnt <= ackCnt - 5'h01;
        end
    end
    assign prnAck = (ackCnt != 5'h00) && (ackCnt <= 5'h04);
    // Record struck codes, close the line on done
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pos     <= 8'h00;
            lineLen <= 8'h00;
        end else begin
            if (prnStrobe && pos < 8'(LINE_CHARS)) begin
                codes[pos] <= prnCode;
                pos        <= pos + 8'h01;
            end
            if (prnLineDone) begin
                lineLen <= pos;
                pos     <= 8'h00;
            end
        end
    end
    // Tape moves only while paper advances; one hole per step of 8 cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            step <= 6'h00;
        end else if (paperAdvance) begin
            step <= step + 6'h01;
        end
    end
    assign tapeHole = 8'h01 << step[5:3];
endmodule : lpc_printer_model

//--- sim/test_line_printer_control.sv
`timescale 1ns/1ps
module test_line_printer_control
    import lpc_pkg::*;
;
    localparam logic [11:0] I_CLR = 12'hdaa; // Clear ready
    localparam logic [11:0] I_PRN = 12'hdad; // Print line
    localparam logic [11:0] I_SKP = 12'hdb1; // Skip on ready
    localparam logic [11:0] I_CLB = 12'hdb2; // Clear both sections
    localparam logic [11:0] I_LD  = 12'hdb4; // Load one code
    localparam logic [11:0] I_ALL = 12'hdb7; // Skip, clear both, then load
    logic                sys_clk, rst, psel, penable, pwrite, slow;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rdata;
    logic                pready, pslverr, irq, skipReq, rerr;
    logic [CHAR_W-1:0]   prnCode;
    logic                prnStrobe, prnLineDone, prnAck, paperAdvance, advPrev;
    logic [CHANNELS-1:0] tapeHole, stopHole;
    int                  miscompares, nChecks, skips, advRises;
    // Design with short load and line times
    lpc_line_printer_control #(.LOAD_CYC(20), .LINE_CYC(50)) dut (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .skipReq(skipReq),
        .prnCode(prnCode), .prnStrobe(prnStrobe), .prnLineDone(prnLineDone),
        .prnAck(prnAck), .paperAdvance(paperAdvance), .tapeHole(tapeHole));
    // Printer and format tape
    lpc_printer_model model (
        .sys_clk(sys_clk), .rst(rst), .slow(slow), .prnCode(prnCode),
        .prnStrobe(prnStrobe), .prnLineDone(prnLineDone), .prnAck(prnAck),
        .paperAdvance(paperAdvance), .tapeHole(tapeHole));
    always #4 sys_clk = ~sys_clk;
    // Count skip pulses and advances, note holes where advance stops
    always @(posedge sys_clk) begin
        if (skipReq === 1'b1) skips++;
        if (paperAdvance === 1'b1 && advPrev === 1'b0) advRises++;
        if (advPrev === 1'b1 && paperAdvance === 1'b0) stopHole = tapeHole;
        advPrev = paperAdvance;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // One APB transfer, answer taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [11:0] ir, input logic [11:0] ac);
        apb(1'b1, REG_CMD, {8'h00, ir, ac});
    endtask : cmd
    // Poll one state bit under a bound
    task automatic waitState(input int b, input logic v);
        for (int i = 0; i < 4000 && rdata[b] !== v; i++) apb(1'b0, REG_STATE, 32'h0000_0000);
        chk("state bit", {31'h0, v}, {31'h0, rdata[b]});
    endtask : waitState
    task automatic load(input logic [5:0] c);
        cmd(I_LD, {6'h00, c});
        apb(1'b0, REG_STATE, 32'h0000_0000);
        waitState(SR_READY, 1'b1);
    endtask : load
    // Print with format and advance bit, then wait for idle
    task automatic print(input logic [2:0] f, input logic adv);
        cmd(I_PRN, {8'h00, adv, f});
        apb(1'b0, REG_STATE, 32'h0000_0000);
        waitState(SR_BUSY, 1'b0);
        chk("format", {29'h0, f}, {29'h0, rdata[10:8]});
        chk("line length", 8'd120, model.lineLen);
    endtask : print
    task automatic giveVerdict;
        $display("Checks %0d errors %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : giveVerdict
    initial begin
        #800000;
        miscompares++;
        giveVerdict();
    end
    initial begin
        {sys_clk, psel, penable, pwrite, slow, advPrev} = 6'h00;
        {paddr, pwdata, rdata, stopHole} = 80'h0;
        {miscompares, nChecks, skips, advRises} = 128'h0;
        rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, REG_STATE, 32'h0000_0000);
        chk("ready at reset", 1, rdata[SR_READY]);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 1, rerr);
        // First load: ready drops, then rises
        cmd(I_LD, 12'h015);
        apb(1'b0, REG_STATE, 32'h0000_0000);
        chk("ready in load", 0, rdata[SR_READY]);
        waitState(SR_READY, 1'b1);
        load(6'h2a);
        load(6'h3f);
        chk("load count", 3, rdata[22:16]);
        // Interrupt raised by ready, masked, cleared
        apb(1'b1, REG_MASK, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("ready status", 1, rdata[ST_READY]);
        chk("irq set", 1, irq);
        apb(1'b1, REG_STATUS, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("irq cleared", 0, irq);
        apb(1'b1, REG_MASK, 32'h0000_0000);
        // Skip with ready set, then cleared
        cmd(I_SKP, 12'h000);
        apb(1'b0, REG_CMD, 32'h0000_0000);
        chk("skip taken", 1, rdata[0]);
        chk("skip pulses", 1, skips);
        cmd(I_CLR, 12'h000);
        apb(1'b0, REG_STATE, 32'h0000_0000);
        chk("ready cleared", 0, rdata[SR_READY]);
        cmd(I_SKP, 12'h000);
        apb(1'b0, REG_CMD, 32'h0000_0000);
        chk("skip refused", 0, rdata[0]);
        chk("no skip pulse", 1, skips);
        // Print with advance, load the other section meanwhile
        cmd(I_PRN, 12'h00a);
        load(6'h22);
        waitState(SR_BUSY, 1'b0);
        chk("line len", 8'd120, model.lineLen);
        chk("code 0", 6'h15, model.codes[0]);
        chk("code 2", 6'h3f, model.codes[2]);
        chk("code 3", 6'h00, model.codes[3]);
        chk("advanced", 1, advRises);
        chk("stop hole", 1, stopHole[2]);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("line events", 3, rdata[2:1]);
        print(3'h3, 1'b0);
        chk("second line", 6'h22, model.codes[0]);
        chk("no advance", 1, advRises);
        print(3'h1, 1'b0);
        chk("emptied section", 6'h00, model.codes[0]);
        // Clear both sections after a load
        load(6'h33);
        cmd(I_CLB, 12'h000);
        apb(1'b0, REG_STATE, 32'h0000_0000);
        chk("count cleared", 0, rdata[22:16]);
        print(3'h0, 1'b0);
        chk("cleared line", 6'h00, model.codes[0]);
        // Pulses act in ascending order: skip, clear, load at position 0
        cmd(I_ALL, 12'h011);
        apb(1'b0, REG_STATE, 32'h0000_0000);
        waitState(SR_READY, 1'b1);
        chk("combined load", 1, rdata[22:16]);
        chk("combined skip", 2, skips);
        // Every format channel, printer fast and slow
        for (int f = 0; f < CHANNELS; f++) begin
            slow <= f[0];
            print(3'(f), 1'b1);
            chk("advance count", f + 2, advRises);
            chk("channel hole", 1, stopHole[f]);
        end
        giveVerdict();
    end
endmodule : test_line_printer_control
